// ==== rtl/flash_config_id_registers.sv ====
// Flash configuration and identifier register bank with flash power gating.
// Assumes an Avalon-MM master on clk_in and doze/flash signals on clk_in.
//
// Overview of operation
// R1 - Read-only four-bit code reports program flash size and protection region.
// R2 - The size code is a fixed device value; software cannot change it.
// R3 - Doze-off bit 1 set turns flash off while doze lasts.
// R4 - Flash turns back on by itself when doze ends.
// R5 - Doze wake-up is lengthened while flash is re-enabled.
// R6 - Flash access while flash is off in doze gets a bus error.
// R7 - Software keeps the doze-off bit clear in very low power modes.
// R8 - Disable bit 0 set gives bus errors and holds flash in low power.
// R9 - Software should not change the disable bit in very low power modes.
// R10 - Software moves vectors out of flash before setting the disable bit.
// R11 - Seven-bit read-only block 0 limit; 0x10 means a 128 KB block.
// R12 - Seven-bit read-only block 1 limit added to block 0 limit.
// R13 - Both limit fields hold fixed device values for implemented flash.
// R14 - Limit register bit 23 always reads one.
// R15 - All other reserved bits read zero and ignore writes.
// R16 - Low sixteen bits of the mid-high identifier hold the unique serial.
// R17 - Power-control bits clear at reset; read-only field writes are ignored.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
module flash_config_id_registers #(
   parameter logic [3:0] SIZE_CODE = flash_cfg_pkg::DEF_SIZE_CODE,
   parameter logic [6:0] BLOCK0_LIMIT = flash_cfg_pkg::DEF_BLOCK0_LIMIT,
   parameter logic [6:0] BLOCK1_LIMIT = flash_cfg_pkg::DEF_BLOCK1_LIMIT,
   // Arbitrary default; each part carries its own serial.
   parameter logic [15:0] UNIQUE_SERIAL = flash_cfg_pkg::DEF_UNIQUE_SERIAL,
   parameter int WAKE_CYCLES = flash_cfg_pkg::FLASH_WAKE_CYCLES
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_in,

   // Avalon-MM slave.
   input wire logic [15:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic [1:0] avs_response_out,

   // Low-power mode state from the mode controller.
   input wire logic doze_in,
   output logic doze_wake_hold_out,

   // Flash access path.
   input wire logic flash_access_in,
   output logic flash_bus_error_out,
   output logic flash_power_on_out,
   output logic flash_ready_out,

   // Decoded flash geometry.
   output logic [3:0] program_flash_size_code_out,
   output logic [31:0] block0_end_out,
   output logic [31:0] block1_end_out
);

   // ------------------------------------------------------------------
   // Request capture.
   // ------------------------------------------------------------------

   flash_cfg_pkg::bus_req_s req;
   flash_cfg_pkg::flash_ctrl_s ctrl_q;
   flash_cfg_pkg::flash_ctrl_s ctrl_d;
   logic ack_q;
   logic [31:0] readdata_q;
   logic [1:0] response_q;
   logic [31:0] block0_end_q;
   logic [31:0] block1_end_q;

   // Bundle the bus inputs so the decode sees one request object.
   assign req.read = avs_read_in;
   assign req.write = avs_write_in;
   assign req.address = avs_address_in;
   assign req.writedata = avs_writedata_in;
   assign req.byteenable = avs_byteenable_in;

   // ------------------------------------------------------------------
   // Address decode.
   // ------------------------------------------------------------------

   // Maps a byte address to a register selector; read and write both use it.
   function automatic logic [1:0] reg_sel(input logic [15:0] addr);
      logic [1:0] sel;
      sel = flash_cfg_pkg::SEL_NONE;
      if (addr == flash_cfg_pkg::OFS_FLASH_CONFIG_ONE) begin
         sel = flash_cfg_pkg::SEL_CONFIG;
      end else if (addr == flash_cfg_pkg::OFS_FLASH_LIMIT_CONFIG) begin
         sel = flash_cfg_pkg::SEL_LIMIT;
      end else if (addr == flash_cfg_pkg::OFS_UNIQUE_ID_MID_HIGH) begin
         sel = flash_cfg_pkg::SEL_SERIAL;
      end
      return sel;
   endfunction : reg_sel

   wire [1:0] sel_now;
   wire active;
   wire accept;
   wire write_accept;
   wire cfg_write;
   wire mapped;

   assign sel_now = reg_sel(req.address);
   assign mapped = (sel_now != flash_cfg_pkg::SEL_NONE);
   assign active = req.read | req.write;

   // Every request waits exactly one cycle; the answer is ready after it.
   // A fixed single wait keeps the read mux off the bus timing path.
   assign avs_waitrequest_out = active & ~ack_q;
   assign accept = active & ack_q;
   assign write_accept = accept & req.write;

   // Only the control byte of flash_config_one is writable; all other
   // fields, including the whole limit and serial words, drop writes.
   assign cfg_write = write_accept
      & (sel_now == flash_cfg_pkg::SEL_CONFIG)
      & req.byteenable[0]; // R15 R17

   // ------------------------------------------------------------------
   // Read words.
   // ------------------------------------------------------------------

   wire [31:0] word_config;
   wire [31:0] word_limit;
   wire [31:0] word_serial;
   wire [31:0] read_mux;

   // Size code is a build-time constant; nothing on the bus reaches it.
   assign word_config = {4'h0, SIZE_CODE, 22'h000000,
      ctrl_q.off_in_doze, ctrl_q.off_control}; // R1 R2 R15

   // Limit fields are constants; bit 23 is tied high, the rest of the
   // reserved bits read low.
   assign word_limit = {1'b0, BLOCK0_LIMIT,
      flash_cfg_pkg::LIMIT_ONE_BIT_VALUE, BLOCK1_LIMIT,
      16'h0000}; // R11 R12 R13 R14 R15

   // Upper half of the identifier word reads zero.
   assign word_serial = {16'h0000, UNIQUE_SERIAL}; // R15 R16

   assign read_mux =
      (sel_now == flash_cfg_pkg::SEL_CONFIG) ? word_config :
      (sel_now == flash_cfg_pkg::SEL_LIMIT) ? word_limit :
      (sel_now == flash_cfg_pkg::SEL_SERIAL) ? word_serial :
      32'h00000000;

   // ------------------------------------------------------------------
   // Control register next value.
   // ------------------------------------------------------------------

   // Both power bits sit in byte lane 0 and load together.
   always_comb begin
      ctrl_d = ctrl_q;
      if (cfg_write) begin
         ctrl_d.off_in_doze =
            req.writedata[flash_cfg_pkg::POS_OFF_IN_DOZE]; // R3
         ctrl_d.off_control =
            req.writedata[flash_cfg_pkg::POS_OFF_CONTROL]; // R8
      end
   end

   // ------------------------------------------------------------------
   // Bus handshake and answer registers.
   // ------------------------------------------------------------------

   // The acknowledge toggles high for one cycle per request; the ~ack_q term
   // clears it on the next edge, so it never stays up even while a request is held.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= active & ~ack_q;
      end
   end

   // Read data and response are loaded in the wait cycle so they stand
   // steady for the whole cycle in which waitrequest is low.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         readdata_q <= 32'h00000000;
         response_q <= flash_cfg_pkg::RESP_OKAY;
      end else if (active & ~ack_q) begin
         readdata_q <= req.read ? read_mux : 32'h00000000;
         response_q <= mapped ? flash_cfg_pkg::RESP_OKAY
            : flash_cfg_pkg::RESP_DECODE_ERROR;
      end
   end

   // Flash power controls start cleared so flash comes up enabled.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ctrl_q.off_in_doze <= flash_cfg_pkg::RST_OFF_IN_DOZE; // R17
         ctrl_q.off_control <= flash_cfg_pkg::RST_OFF_CONTROL; // R17
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   assign avs_readdata_out = readdata_q;
   assign avs_response_out = response_q;

   // ------------------------------------------------------------------
   // Flash geometry outputs.
   // ------------------------------------------------------------------

   wire [31:0] block0_end;
   wire [31:0] block1_end;
   wire [7:0] limit_sum;

   // Each limit count is 8 KB, so a count of 0x10 ends at 0x0002_0000.
   assign block0_end = {25'h0000000, BLOCK0_LIMIT}
      << flash_cfg_pkg::LIMIT_SHIFT; // R11
   assign limit_sum = {1'b0, BLOCK0_LIMIT} + {1'b0, BLOCK1_LIMIT};
   assign block1_end = {24'h000000, limit_sum}
      << flash_cfg_pkg::LIMIT_SHIFT; // R12

   // Registered so the two block end outputs come from flip-flops.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         block0_end_q <= 32'h00000000;
         block1_end_q <= 32'h00000000;
      end else begin
         block0_end_q <= block0_end;
         block1_end_q <= block1_end;
      end
   end

   assign block0_end_out = block0_end_q;
   assign block1_end_out = block1_end_q;
   assign program_flash_size_code_out = SIZE_CODE; // R1

   // ------------------------------------------------------------------
   // Flash power sequencing.
   // ------------------------------------------------------------------

   // Software must keep off_in_doze clear in very low power modes; the
   // sequencer does not police that and simply follows the bits.
   flash_power_gate #(
      .WAKE_CYCLES(WAKE_CYCLES)
   ) power_gate (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .ctrl_in(ctrl_q),
      .doze_in(doze_in),
      .flash_access_in(flash_access_in),
      .power_on_out(flash_power_on_out),
      .ready_out(flash_ready_out),
      .bus_error_out(flash_bus_error_out), // R6 R8
      .wake_hold_out(doze_wake_hold_out) // R4 R5
   );

endmodule : flash_config_id_registers

// ==== rtl/flash_cfg_pkg.sv ====
// Shared constants and types for the flash configuration and identifier bank.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and a 10 MHz clock.
package flash_cfg_pkg;

   // Bus geometry.
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;

   // Register byte offsets.
   localparam logic [15:0] OFS_FLASH_CONFIG_ONE = 16'h104c;
   localparam logic [15:0] OFS_FLASH_LIMIT_CONFIG = 16'h1050;
   localparam logic [15:0] OFS_UNIQUE_ID_MID_HIGH = 16'h1058;

   // Field positions in flash_config_one.
   localparam int POS_SIZE_CODE = 24;
   localparam int POS_OFF_IN_DOZE = 1;
   localparam int POS_OFF_CONTROL = 0;

   // Field positions in flash_limit_config.
   localparam int POS_BLOCK0_LIMIT = 24;
   localparam int POS_LIMIT_ONE_BIT = 23;
   localparam int POS_BLOCK1_LIMIT = 16;

   // A limit count of one stands for 8 KB of address space.
   localparam int LIMIT_SHIFT = 13;

   // Reset values and fixed values.
   localparam logic RST_OFF_IN_DOZE = 1'b0;
   localparam logic RST_OFF_CONTROL = 1'b0;
   localparam logic LIMIT_ONE_BIT_VALUE = 1'b1;

   // Default device values; the serial default is arbitrary.
   localparam logic [3:0] DEF_SIZE_CODE = 4'h7;
   localparam logic [6:0] DEF_BLOCK0_LIMIT = 7'h10;
   localparam logic [6:0] DEF_BLOCK1_LIMIT = 7'h00;
   localparam logic [15:0] DEF_UNIQUE_SERIAL = 16'h5a3c;

   // Avalon-MM response codes.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECODE_ERROR = 2'h3;

   // Timing: flash re-enable time and clock period.
   localparam int FLASH_WAKE_NS = 1000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int FLASH_WAKE_RAW =
      (FLASH_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLASH_WAKE_CYCLES = (FLASH_WAKE_RAW < 1) ? 1 : FLASH_WAKE_RAW;

   // Register selector codes.
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_CONFIG = 2'h1;
   localparam logic [1:0] SEL_LIMIT = 2'h2;
   localparam logic [1:0] SEL_SERIAL = 2'h3;

   // Flash power states.
   typedef enum logic [2:0] {
      PWR_ON = 3'b001,
      PWR_OFF = 3'b010,
      PWR_WAKE = 3'b100
   } flash_pwr_e;

   // One bus request as seen by the slave.
   typedef struct packed {
      logic read;
      logic write;
      logic [15:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } bus_req_s;

   // Software flash power controls.
   typedef struct packed {
      logic off_in_doze;
      logic off_control;
   } flash_ctrl_s;

endpackage : flash_cfg_pkg

// ==== rtl/flash_power_gate.sv ====
// Flash power sequencer: turns flash off and on and refuses access while off.
// Assumes doze and flash access requests come from logic on the same clock.
`timescale 1ns/1ps
module flash_power_gate #(
   parameter int WAKE_CYCLES = flash_cfg_pkg::FLASH_WAKE_CYCLES
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_in,
   // Controls from the register bank.
   input wire flash_cfg_pkg::flash_ctrl_s ctrl_in,
   input wire logic doze_in,
   // Flash access from any bus master.
   input wire logic flash_access_in,
   // Status towards flash and the mode controller.
   output logic power_on_out,
   output logic ready_out,
   output logic bus_error_out,
   output logic wake_hold_out
);

   localparam logic [15:0] WAKE_LAST = 16'(WAKE_CYCLES - 1);

   flash_cfg_pkg::flash_pwr_e state_q;
   flash_cfg_pkg::flash_pwr_e state_d;
   logic [15:0] wake_cnt_q;
   logic [15:0] wake_cnt_d;
   logic bus_error_q;
   wire want_off;
   wire wake_done;

   // Flash goes off when disabled outright or when dozing with doze-off set.
   assign want_off = ctrl_in.off_control
      | (ctrl_in.off_in_doze & doze_in); // R3 R8
   assign wake_done = (wake_cnt_q == 16'h0000);

   // Leaving the off state other than by reset always passes through a timed wake so the flash
   // is stable before anyone is allowed to fetch from it.
   always_comb begin
      state_d = state_q;
      wake_cnt_d = wake_cnt_q;
      case (state_q)
         flash_cfg_pkg::PWR_ON: begin
            if (want_off) begin
               state_d = flash_cfg_pkg::PWR_OFF;
            end
         end
         flash_cfg_pkg::PWR_OFF: begin
            if (!want_off) begin
               state_d = flash_cfg_pkg::PWR_WAKE; // R4
               wake_cnt_d = WAKE_LAST;
            end
         end
         flash_cfg_pkg::PWR_WAKE: begin
            if (want_off) begin
               state_d = flash_cfg_pkg::PWR_OFF;
            end else if (wake_done) begin
               state_d = flash_cfg_pkg::PWR_ON;
            end else begin
               wake_cnt_d = wake_cnt_q - 16'h0001;
            end
         end
         default: begin
            state_d = flash_cfg_pkg::PWR_ON;
         end
      endcase
   end

   // State, wake counter and the registered access error.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_q <= flash_cfg_pkg::PWR_ON;
         wake_cnt_q <= 16'h0000;
         bus_error_q <= 1'b0;
      end else begin
         state_q <= state_d;
         wake_cnt_q <= wake_cnt_d;
         bus_error_q <= flash_access_in & ~ready_out; // R6 R8
      end
   end

   assign power_on_out = (state_q != flash_cfg_pkg::PWR_OFF);
   assign ready_out = (state_q == flash_cfg_pkg::PWR_ON);
   assign bus_error_out = bus_error_q;
   // Doze exit is held until the flash is back, which lengthens wake-up.
   assign wake_hold_out = ~doze_in & ~ready_out
      & ~ctrl_in.off_control; // R5

endmodule : flash_power_gate

// ==== test/flash_cfg_chk.sv ====
// Concurrent checks on the ports of the flash configuration bank.
// Assumes one clock and the synchronous active-high reset of the bank.
`timescale 1ns/1ps
module flash_cfg_chk #(
   parameter logic [3:0] SIZE_CODE = 4'h0,
   parameter logic [6:0] BLOCK0_LIMIT = 7'h00,
   parameter logic [6:0] BLOCK1_LIMIT = 7'h00,
   parameter logic [15:0] UNIQUE_SERIAL = 16'h0000,
   parameter int WAKE_CYCLES = 2
) (
   // Clock, reset and bus.
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [15:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // Flash power and geometry.
   input wire logic doze_in,
   input wire logic doze_wake_hold_out,
   input wire logic flash_access_in,
   input wire logic flash_bus_error_out,
   input wire logic flash_power_on_out,
   input wire logic flash_ready_out,
   input wire logic [3:0] program_flash_size_code_out,
   input wire logic [31:0] block0_end_out,
   input wire logic [31:0] block1_end_out
);
   // All checks share the bus clock and its reset.
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // A read is answered in the cycle that waitrequest is low.
   wire rd_ok = avs_read_in & ~avs_waitrequest_out;
   wire [31:0] rd = avs_readdata_out;
   wire [7:0] b_sum = {1'b0, BLOCK0_LIMIT} + {1'b0, BLOCK1_LIMIT};

   property p_size; program_flash_size_code_out == SIZE_CODE; endproperty
   a_size: assert property (p_size) else $error("size code moved");
   property p_cfg;
      rd_ok && avs_address_in == flash_cfg_pkg::OFS_FLASH_CONFIG_ONE |->
         rd[31:28] == 4'h0 && rd[27:24] == SIZE_CODE && rd[23:2] == 22'h0;
   endproperty
   a_cfg: assert property (p_cfg) else $error("config readback bad");
   property p_lim;
      rd_ok && avs_address_in == flash_cfg_pkg::OFS_FLASH_LIMIT_CONFIG |->
         rd == {1'b0, BLOCK0_LIMIT, 1'b1, BLOCK1_LIMIT, 16'h0000};
   endproperty
   a_lim: assert property (p_lim) else $error("limit readback bad");
   property p_uid;
      rd_ok && avs_address_in == flash_cfg_pkg::OFS_UNIQUE_ID_MID_HIGH |->
         rd == {16'h0000, UNIQUE_SERIAL};
   endproperty
   a_uid: assert property (p_uid) else $error("serial readback bad");
   property p_b0;
      !$past(reset_in) |-> block0_end_out == {12'h000, BLOCK0_LIMIT, 13'h0};
   endproperty
   a_b0: assert property (p_b0) else $error("block 0 end bad");
   property p_b1;
      !$past(reset_in) |-> block1_end_out == {11'h000, b_sum, 13'h0};
   endproperty
   a_b1: assert property (p_b1) else $error("block 1 end bad");
   property p_err;
      flash_access_in && !flash_ready_out |=> flash_bus_error_out;
   endproperty
   a_err: assert property (p_err) else $error("no bus error");
   property p_noerr; !flash_access_in |=> !flash_bus_error_out; endproperty
   a_noerr: assert property (p_noerr) else $error("stray bus error");
   // The wake span follows the sequencer's count; a reset release lifts
   // power_on straight into the ready state, so it is not a wake.
   localparam int WAKE_LAST = WAKE_CYCLES - 1;
   property p_wake;
      $rose(flash_power_on_out) && !$past(reset_in) |->
         !flash_ready_out ##WAKE_LAST !flash_ready_out ##1 flash_ready_out;
   endproperty
   a_wake: assert property (p_wake) else $error("wake length bad");
   property p_hold;
      !doze_in && flash_power_on_out && !flash_ready_out |->
         doze_wake_hold_out;
   endproperty
   a_hold: assert property (p_hold) else $error("wake not held");
endmodule : flash_cfg_chk

bind flash_config_id_registers flash_cfg_chk #(
   .SIZE_CODE(SIZE_CODE), .BLOCK0_LIMIT(BLOCK0_LIMIT),
   .BLOCK1_LIMIT(BLOCK1_LIMIT), .UNIQUE_SERIAL(UNIQUE_SERIAL),
   .WAKE_CYCLES(WAKE_CYCLES)
) chk_u (
   .clk_in(clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .doze_in(doze_in),
   .doze_wake_hold_out(doze_wake_hold_out),
   .flash_access_in(flash_access_in),
   .flash_bus_error_out(flash_bus_error_out),
   .flash_power_on_out(flash_power_on_out),
   .flash_ready_out(flash_ready_out),
   .program_flash_size_code_out(program_flash_size_code_out),
   .block0_end_out(block0_end_out), .block1_end_out(block1_end_out)
);

// ==== test/avalon_master_model.sv ====
// Avalon-MM master standing in for the processor or a DMA engine.
// Assumes a slave that answers by lowering waitrequest on the same clock.
`timescale 1ns/1ps
module avalon_master_model (
   // Bus clock.
   input wire logic clk_in,
   // Requests towards the slave.
   output logic [15:0] address_out,
   output logic read_out,
   output logic write_out,
   output logic [31:0] writedata_out,
   output logic [3:0] byteenable_out,
   // Answers from the slave.
   input wire logic [31:0] readdata_in,
   input wire logic waitrequest_in,
   input wire logic [1:0] response_in
);
   // Idle bus at time zero.
   initial begin
      address_out = 16'h0000;
      read_out = 1'b0;
      write_out = 1'b0;
      writedata_out = 32'h0;
      byteenable_out = 4'h0;
   end

   // One whole transfer; callers never touch power bits in very low power
   // modes and keep vectors out of flash before disabling it.
   task automatic xfer(input logic wr, input logic [15:0] a,
      input logic [31:0] wd, input logic [3:0] be,
      output logic [31:0] rd, output logic [1:0] rs);
      @(posedge clk_in);
      address_out <= a;
      read_out <= ~wr;
      write_out <= wr;
      writedata_out <= wd;
      byteenable_out <= be;
      do @(posedge clk_in); while (waitrequest_in !== 1'b0);
      rd = readdata_in;
      rs = response_in;
      read_out <= 1'b0;
      write_out <= 1'b0;
      // Released address and write data are inverted so stale values cannot pass as valid.
      address_out <= ~a;
      writedata_out <= ~wd;
   endtask : xfer
endmodule : avalon_master_model

// ==== test/flash_config_id_registers_tb.sv ====
// Self-checking bench for the flash configuration and identifier bank.
// Assumes the bus master model and the bound checker are compiled with it.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module flash_config_id_registers_tb;
   // Device values chosen away from the defaults except the block 0 limit; the serial is arbitrary.
   localparam logic [3:0] SZ = 4'h9;
   localparam logic [6:0] B0 = 7'h10;
   localparam logic [6:0] B1 = 7'h08;
   localparam logic [15:0] SER = 16'h3c5a;
   localparam int WAKE = 2;
   localparam logic [1:0] OK = flash_cfg_pkg::RESP_OKAY;
   localparam logic [1:0] DEC = flash_cfg_pkg::RESP_DECODE_ERROR;
   localparam logic [15:0] A_CFG = flash_cfg_pkg::OFS_FLASH_CONFIG_ONE;
   localparam logic [15:0] A_LIM = flash_cfg_pkg::OFS_FLASH_LIMIT_CONFIG;
   localparam logic [15:0] A_UID = flash_cfg_pkg::OFS_UNIQUE_ID_MID_HIGH;
   logic clk_in, reset_in, doze_in, flash_access_in;
   logic rd_q, wr_q, wait_q, hold, err, pwr, rdy;
   logic [15:0] addr;
   logic [31:0] wdata, rdata, e0, e1;
   logic [3:0] be, szo;
   logic [1:0] resp;
   int error_cnt = 0;
   int n_checks = 0;

   // Design and bus master.
   avalon_master_model pm_u (.clk_in(clk_in), .address_out(addr),
      .read_out(rd_q), .write_out(wr_q), .writedata_out(wdata),
      .byteenable_out(be), .readdata_in(rdata), .waitrequest_in(wait_q),
      .response_in(resp));
   flash_config_id_registers #(.SIZE_CODE(SZ), .BLOCK0_LIMIT(B0),
      .BLOCK1_LIMIT(B1), .UNIQUE_SERIAL(SER), .WAKE_CYCLES(WAKE)) dut_u (
      .clk_in(clk_in), .reset_in(reset_in), .avs_address_in(addr),
      .avs_read_in(rd_q), .avs_write_in(wr_q), .avs_writedata_in(wdata),
      .avs_byteenable_in(be), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wait_q), .avs_response_out(resp),
      .doze_in(doze_in), .doze_wake_hold_out(hold),
      .flash_access_in(flash_access_in), .flash_bus_error_out(err),
      .flash_power_on_out(pwr), .flash_ready_out(rdy),
      .program_flash_size_code_out(szo), .block0_end_out(e0),
      .block1_end_out(e1));

   // Free-running 10 MHz clock.
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   function automatic logic [31:0] cfg(input logic [1:0] b);
      return {4'h0, SZ, 22'h0, b};
   endfunction : cfg

   // Bus helpers: a read compared with its value, a write with its code.
   task automatic rchk(input logic [15:0] a, input logic [31:0] x,
      input logic [1:0] xr);
      logic [31:0] d;
      logic [1:0] r;
      pm_u.xfer(1'b0, a, 32'h0, 4'hf, d, r);
      `CHK(d, x)
      `CHK(r, xr)
   endtask : rchk
   task automatic wchk(input logic [15:0] a, input logic [31:0] v,
      input logic [3:0] m, input logic [1:0] xr);
      logic [31:0] d;
      logic [1:0] r;
      pm_u.xfer(1'b1, a, v, m, d, r);
      `CHK(r, xr)
   endtask : wchk
   // One-cycle flash access; the error, if any, shows one cycle later.
   task automatic acc(input logic x);
      @(posedge clk_in);
      flash_access_in <= 1'b1;
      @(posedge clk_in);
      flash_access_in <= 1'b0;
      @(negedge clk_in);
      `CHK(err, x)
   endtask : acc

   task automatic test_done();
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done

   // Main sequence; power state is seen as {power_on, ready, hold}.
   initial begin
      reset_in = 1'b1;
      doze_in = 1'b0;
      flash_access_in = 1'b0;
      repeat (6) @(posedge clk_in);
      reset_in <= 1'b0;
      rchk(A_CFG, cfg(2'b00), OK);
      `CHK(szo, SZ)
      `CHK(e0, 32'h0002_0000)
      `CHK(e1, 32'h0003_0000)
      acc(1'b0);
      wchk(A_LIM, 32'hffff_ffff, 4'hf, OK);
      wchk(A_UID, 32'hffff_ffff, 4'hf, OK);
      rchk(A_LIM, {1'b0, B0, 1'b1, B1, 16'h0}, OK);
      rchk(A_UID, {16'h0, SER}, OK);
      rchk(16'h1054, 32'h0, DEC);
      wchk(16'h1054, 32'hffff_ffff, 4'hf, DEC);
      // Doze bit clear: flash stays on through doze.
      doze_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      `CHK({pwr, rdy, hold}, 3'b110)
      @(posedge clk_in);
      doze_in <= 1'b0;
      wchk(A_CFG, 32'hffff_fffe, 4'hf, OK);
      rchk(A_CFG, cfg(2'b10), OK);
      acc(1'b0);
      @(posedge clk_in);
      doze_in <= 1'b1;
      @(posedge clk_in);
      @(negedge clk_in);
      `CHK({pwr, rdy, hold}, 3'b000)
      acc(1'b1);
      @(posedge clk_in);
      doze_in <= 1'b0;
      @(posedge clk_in);
      @(negedge clk_in);
      `CHK({pwr, rdy, hold}, 3'b101)
      repeat (WAKE) @(posedge clk_in);
      @(negedge clk_in);
      `CHK({pwr, rdy, hold}, 3'b110)
      acc(1'b0);
      // Disable bit; the write needs byte lane 0.
      wchk(A_CFG, 32'h1, 4'h1, OK);
      @(posedge clk_in);
      @(negedge clk_in);
      `CHK({pwr, rdy}, 2'b00)
      acc(1'b1);
      wchk(A_CFG, 32'h0, 4'he, OK);
      rchk(A_CFG, cfg(2'b01), OK);
      wchk(A_CFG, 32'h0, 4'hf, OK);
      repeat (WAKE + 1) @(posedge clk_in);
      acc(1'b0);
      // A reset in mid-run clears both power bits.
      wchk(A_CFG, 32'h3, 4'hf, OK);
      @(posedge clk_in);
      reset_in <= 1'b1;
      @(posedge clk_in);
      reset_in <= 1'b0;
      rchk(A_CFG, cfg(2'b00), OK);
      acc(1'b0);
      test_done();
   end

   // Watchdog well beyond the fewer than a hundred cycles the sequence needs.
   initial begin
      repeat (3000) @(posedge clk_in);
      error_cnt++;
      test_done();
   end
endmodule : flash_config_id_registers_tb
